// ==== dv/ccsc_cache_config_chain_tb_top.sv ====
// Bench for the chain: reference, init-mode and copy-mismatch loads.
// Assumes the checker binds itself to the top module.
`timescale 1ns/1ps
`define CHK(n,e,a) cmp_count++; if ((a)!==(e)) begin err_count++; $display("[FAIL] %s exp %h got %h",n,e,a); end
module ccsc_cache_config_chain_tb_top;
  logic mclk = 0, sys_rst = 1, chain_data_port_wr = 0;
  logic l2_cache_enable_q, init_mode_q, evict_enable_q, l2_bank_mode_q;
  logic load_done_q, copy_mismatch_q;
  logic [5:0] chain_data_port = 6'h00;
  logic [35:0] cache_config_chain_q, old;
  logic [3:0] l2_size_code_q, init_line_state_q;
  logic [1:0] full_line_write_ack_cfg_q;
  logic [2:0] set_modified_ack_q;
  int err_count = 0, cmp_count = 0, cyc = 0;
  ccsc_cache_config_chain ccsc_cache_config_chain_i (.*);
  initial forever #4 mclk = ~mclk;
  always @(posedge mclk) if (++cyc > 3000) begin
    err_count++;
    print_verdict();
  end
  task automatic load(input logic [35:0] tx, input logic [35:0] img);
    old = cache_config_chain_q;
    for (int i = 0; i < 6; i++) begin
      @(negedge mclk);
      `CHK("hold", old, cache_config_chain_q)
      chain_data_port_wr = 1;
      chain_data_port = tx[6*i +: 6];
    end
    @(negedge mclk);
    chain_data_port_wr = 0;
    `CHK("done", 1'b1, load_done_q)
    @(negedge mclk);
    `CHK("chain", img, cache_config_chain_q)
    `CHK("pulse", 1'b0, load_done_q)
  endtask
  task t_reference;
    load(36'hf7ffeffc1, 36'h07fbffffd);
    `CHK("fields", 18'h2ffa0, {l2_cache_enable_q, init_mode_q, l2_size_code_q, full_line_write_ack_cfg_q, evict_enable_q, set_modified_ack_q, l2_bank_mode_q, init_line_state_q, copy_mismatch_q})
  endtask
  task t_init;
    load(36'h08000002a, 36'ha80000002);
    `CHK("init", 7'h68, {init_mode_q, init_line_state_q, copy_mismatch_q, l2_cache_enable_q})
  endtask
  task t_mismatch;
    load(36'h040000000, 36'h000000001);
    `CHK("mismatch", 2'h3, {copy_mismatch_q, l2_cache_enable_q})
  endtask
  task t_reset_midload;
    for (int i = 0; i < 3; i++) begin
      @(negedge mclk);
      chain_data_port_wr = 1;
      chain_data_port = 6'h3f;
    end
    @(negedge mclk);
    chain_data_port_wr = 0;
    sys_rst = 1;
    repeat (2) @(negedge mclk);
    sys_rst = 0;
    `CHK("rst mid", 37'h0, {cache_config_chain_q, load_done_q})
    t_reference();
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    sys_rst = 0;
    `CHK("reset", 37'h0, {cache_config_chain_q, load_done_q})
    t_reference();
    t_init();
    t_mismatch();
    t_reset_midload();
    print_verdict();
  end
endmodule

// ==== dv/ccsc_chain_properties.sv ====
// Checker for the chain top: field decode, commit hold and done timing.
// Assumes the bind below; it sees only the top-level ports.
`timescale 1ns/1ps
module ccsc_chain_props (
  input wire mclk, sys_rst, chain_data_port_wr, load_done_q, l2_cache_enable_q,
  input wire init_mode_q, evict_enable_q, l2_bank_mode_q,
  input wire [35:0] cache_config_chain_q,
  input wire [3:0] l2_size_code_q, init_line_state_q,
  input wire [1:0] full_line_write_ack_cfg_q,
  input wire [2:0] set_modified_ack_q
);
  wire [35:0] c = cache_config_chain_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence s_done_pulse;
    load_done_q ##1 !load_done_q;
  endsequence
  a_enable_bit: assert property (l2_cache_enable_q == c[0]) else $error("enable");
  a_size_field: assert property (l2_size_code_q == c[5:2]) else $error("size");
  a_init_bit: assert property (init_mode_q == c[1]) else $error("init");
  a_evict_bank: assert property ({evict_enable_q, l2_bank_mode_q} == {c[16], c[26]})
    else $error("evict bank");
  a_ack_field: assert property (full_line_write_ack_cfg_q == {c[15], c[18]})
    else $error("ack");
  a_dirty_ack_field: assert property (set_modified_ack_q == {c[25:24], c[22]})
    else $error("dirty ack");
  a_line_state: assert property (init_line_state_q == c[35:32]) else $error("state");
  // The image may only move on the edge after the done pulse.
  a_chain_hold: assert property (!load_done_q |=> $stable(c)) else $error("hold");
  a_done_cause: assert property ($rose(load_done_q) |-> $past(chain_data_port_wr))
    else $error("cause");
  a_done_pulse: assert property ($rose(load_done_q) |-> s_done_pulse) else $error("pulse");
endmodule
bind ccsc_cache_config_chain ccsc_chain_props ccsc_chain_props_i (.*);

// ==== rtl/ccsc_cache_config_chain.v ====
// Top of the cache configuration chain: data port, load counter, decoded fields.
// Assumes privileged firmware writes six groups per load and keeps copies consistent.
// Assumes inputs synchronous to mclk; the chain has no defined reset value and clears to zero.
`timescale 1ns/1ps
`include "ccsc_map.vh"
module ccsc_cache_config_chain (
  input wire mclk,
  input wire sys_rst,
  input wire chain_data_port_wr,
  input wire [5:0] chain_data_port,
  output reg [35:0] cache_config_chain_q,
  output reg l2_cache_enable_q,
  output reg init_mode_q,
  output reg [3:0] l2_size_code_q,
  output reg [1:0] full_line_write_ack_cfg_q,
  output reg evict_enable_q,
  output reg [2:0] set_modified_ack_q,
  output reg l2_bank_mode_q,
  output reg [3:0] init_line_state_q,
  output reg load_done_q,
  output reg copy_mismatch_q
);
  wire [35:0] chain_w;
  reg [2:0] cnt_q;
  reg [2:0] cnt_d;
  reg commit;
  reg [12:0] copy_err;
  wire fld_enable;
  wire fld_init;
  wire [3:0] fld_size;
  wire [1:0] fld_flw_ack;
  wire fld_evict;
  wire [2:0] fld_sm_ack;
  wire fld_bank;
  wire [3:0] fld_line_state;

  ccsc_shift_reg u_shift (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .shift_en(chain_data_port_wr),
    .shift_in(chain_data_port),
    .chain_q(chain_w)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reverse a four-bit copy stored in [0:3] order.
  // Both reversed size copies go through here, so they are judged the same way.
  function [3:0] rev4;
    input [3:0] v;
    begin
      rev4 = {v[0], v[1], v[2], v[3]};
    end
  endfunction

  // An enable copy must follow the primary bit, or read zero while init mode masks it.
  // Nine copies share this test, so the init-mode exception lives in one place.
  function en_copy_bad;
    input copy;
    input en;
    input masked;
    begin
      en_copy_bad = masked ? copy : (copy != en);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Primary copy of every field, picked out of the live chain.
  assign fld_enable = chain_w[`CCSC_POS_EN0];
  assign fld_init = chain_w[`CCSC_POS_INIT0];
  assign fld_size = chain_w[`CCSC_POS_SIZE0 +: 4];
  assign fld_flw_ack = {chain_w[`CCSC_POS_FLW1], chain_w[`CCSC_POS_FLW0]};
  assign fld_evict = chain_w[`CCSC_POS_EVICT];
  assign fld_sm_ack = {chain_w[`CCSC_POS_SMA1 +: 2], chain_w[`CCSC_POS_SMA0]};
  assign fld_bank = chain_w[`CCSC_POS_BANK];
  assign fld_line_state = chain_w[`CCSC_POS_LSTATE +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // One flag per duplicated copy; a probe on copy_err shows which position is off.
  // Copies are checked rather than trusted, so a bad load is visible to debug.
  always @* begin
    copy_err = 13'h0;
    copy_err[0] = en_copy_bad(chain_w[`CCSC_POS_EN1], fld_enable, 1'b0);
    copy_err[1] = en_copy_bad(chain_w[`CCSC_POS_EN2], fld_enable, 1'b0);
    copy_err[2] = rev4(chain_w[`CCSC_POS_SIZER0 +: 4]) != fld_size;
    copy_err[3] = en_copy_bad(chain_w[`CCSC_POS_EN3], fld_enable, fld_init);
    copy_err[4] = en_copy_bad(chain_w[`CCSC_POS_EN4], fld_enable, fld_init);
    copy_err[5] = en_copy_bad(chain_w[`CCSC_POS_EN5], fld_enable, fld_init);
    copy_err[6] = en_copy_bad(chain_w[`CCSC_POS_EN6], fld_enable, 1'b0);
    copy_err[7] = en_copy_bad(chain_w[`CCSC_POS_EN7], fld_enable, 1'b0);
    copy_err[8] = en_copy_bad(chain_w[`CCSC_POS_EN8], fld_enable, 1'b0);
    copy_err[9] = en_copy_bad(chain_w[`CCSC_POS_EN9], fld_enable, 1'b0);
    copy_err[10] = chain_w[`CCSC_POS_FLW0C] != fld_flw_ack[0];
    copy_err[11] = rev4(chain_w[`CCSC_POS_SIZER1 +: 4]) != fld_size;
    copy_err[12] = chain_w[`CCSC_POS_INIT1] != fld_init;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sixth write of a load commits; partial loads leave outputs alone.
  // A stray write that breaks the count of six is only cleared by sys_rst.
  always @* begin
    cnt_d = cnt_q;
    commit = 1'b0;
    if (chain_data_port_wr) begin
      if (cnt_q == `CCSC_LOADS - 3'h1) begin
        cnt_d = 3'h0;
        commit = 1'b1;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 3'h0;
      load_done_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      load_done_q <= commit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output but load_done_q is its own flip-flop and moves only on the edge after load_done_q.
  // Back-to-back loads are safe: a write on that edge has not yet reached chain_w.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cache_config_chain_q <= `CCSC_CHAIN_RST;
    end else if (load_done_q) begin
      cache_config_chain_q <= chain_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded fields, each taken from its primary copy only.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      l2_cache_enable_q <= 1'b0;
    end else if (load_done_q) begin
      l2_cache_enable_q <= fld_enable;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      init_mode_q <= 1'b0;
    end else if (load_done_q) begin
      init_mode_q <= fld_init;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      l2_size_code_q <= 4'h0;
    end else if (load_done_q) begin
      l2_size_code_q <= fld_size;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      full_line_write_ack_cfg_q <= 2'h0;
    end else if (load_done_q) begin
      full_line_write_ack_cfg_q <= fld_flw_ack;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      evict_enable_q <= 1'b0;
    end else if (load_done_q) begin
      evict_enable_q <= fld_evict;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      set_modified_ack_q <= 3'h0;
    end else if (load_done_q) begin
      set_modified_ack_q <= fld_sm_ack;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      l2_bank_mode_q <= 1'b0;
    end else if (load_done_q) begin
      l2_bank_mode_q <= fld_bank;
    end
  end

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      init_line_state_q <= 4'h0;
    end else if (load_done_q) begin
      init_line_state_q <= fld_line_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The diagnostic only reports; a bad image is still committed as loaded.
  // Holding back a bad load would leave the cache on a stale setup with no warning.
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      copy_mismatch_q <= 1'b0;
    end else if (load_done_q) begin
      copy_mismatch_q <= |copy_err;
    end
  end
endmodule

// ==== rtl/ccsc_map.vh ====
// Constants for the cache configuration shift chain.
// Assumes inclusion by bare name from the design files.
`ifndef CCSC_MAP_VH
`define CCSC_MAP_VH
`define CCSC_CHAIN_W 36
`define CCSC_PORT_W 6
`define CCSC_LOADS 3'h6
`define CCSC_CHAIN_RST 36'h000000000
`define CCSC_POS_EN0 0
`define CCSC_POS_INIT0 1
`define CCSC_POS_SIZE0 2
`define CCSC_POS_EN1 6
`define CCSC_POS_EN2 7
`define CCSC_POS_SIZER0 8
`define CCSC_POS_EN3 12
`define CCSC_POS_EN4 13
`define CCSC_POS_EN5 14
`define CCSC_POS_FLW1 15
`define CCSC_POS_EVICT 16
`define CCSC_POS_EN6 17
`define CCSC_POS_FLW0 18
`define CCSC_POS_EN7 19
`define CCSC_POS_EN8 20
`define CCSC_POS_EN9 21
`define CCSC_POS_SMA0 22
`define CCSC_POS_FLW0C 23
`define CCSC_POS_SMA1 24
`define CCSC_POS_BANK 26
`define CCSC_POS_SIZER1 27
`define CCSC_POS_INIT1 31
`define CCSC_POS_LSTATE 32
`endif

// ==== rtl/ccsc_shift_reg.v ====
// Shift register holding the 36-bit chain image.
// Assumes one synchronous write strobe per six-bit group.
`timescale 1ns/1ps
`include "ccsc_map.vh"
module ccsc_shift_reg (
  input wire mclk,
  input wire sys_rst,
  input wire shift_en,
  input wire [5:0] shift_in,
  output reg [35:0] chain_q
);
  // Data enters at the bottom, so after six writes the first group sits in bits [35:30].
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      chain_q <= `CCSC_CHAIN_RST;
    end else if (shift_en) begin
      chain_q <= {chain_q[29:0], shift_in};
    end
  end
endmodule
